// file: verilog/alu_defs.svh
// Constants for the add, subtract and logic execute datapath
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH
`define ALU_REG_PC      4'hF
`define ALU_REG_SP      4'hD
`define ALU_IMM_W       12
`define ALU_PC_ALIGN    32'hFFFF_FFFC
`define ALU_BRANCH_MASK 32'hFFFF_FFFE
`define ALU_FLAGS_RST   4'h0
`endif

// file: verilog/alu_pkg.sv
// Types for the add, subtract and logic execute datapath
package alu_pkg;
  typedef enum logic [3:0] {
    op_add                  = 4'h0,
    op_add_with_carry       = 4'h1,
    op_subtract             = 4'h2,
    subtract_with_borrow    = 4'h3,
    reverse_subtract        = 4'h4,
    op_and                  = 4'h5,
    bitwise_or              = 4'h6,
    bitwise_xor             = 4'h7,
    bit_clear_op            = 4'h8,
    or_not_op               = 4'h9,
    add_wide_immediate      = 4'hA,
    subtract_wide_immediate = 4'hB
  } alu_op_t;
endpackage : alu_pkg

// file: verilog/add_sub_logic_alu.sv
// Add, subtract and logic execute datapath with flag update
`include "alu_defs.svh"
module add_sub_logic_alu
  import alu_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              issue_valid,
  input  wire alu_op_t           op,
  input  wire logic              cond_pass,
  input  wire logic              set_flags,
  input  wire logic              use_immediate,
  input  wire logic [11:0]       twelve_bit_immediate,
  input  wire logic [3:0]        first_operand_reg,
  input  wire logic [DATA_W-1:0] first_operand_val,
  input  wire logic [DATA_W-1:0] flexible_operand,
  input  wire logic              shifter_carry,
  input  wire logic              dest_present,
  input  wire logic [3:0]        dest_reg,
  output logic                   wr_en_ff,
  output logic [3:0]             wr_reg_ff,
  output logic [DATA_W-1:0]      wr_data_ff,
  output logic                   branch_ff,
  output logic [DATA_W-1:0]      branch_target_ff,
  output logic                   flag_n_ff,
  output logic                   flag_z_ff,
  output logic                   flag_c_ff,
  output logic                   flag_v_ff
);

  function automatic logic is_arith(input alu_op_t o);
    is_arith = (o == op_add) || (o == op_add_with_carry) ||
               (o == op_subtract) || (o == subtract_with_borrow) ||
               (o == reverse_subtract) || (o == add_wide_immediate) ||
               (o == subtract_wide_immediate);
  endfunction : is_arith

  logic              nxt_wr_en;
  logic [3:0]        nxt_wr_reg;
  logic [DATA_W-1:0] nxt_wr_data;
  logic              nxt_branch;
  logic [DATA_W-1:0] nxt_branch_target;
  logic              nxt_n;
  logic              nxt_z;
  logic              nxt_c;
  logic              nxt_v;
  logic [DATA_W-1:0] base;
  logic [DATA_W-1:0] opnd_b;
  logic [DATA_W-1:0] add_a;
  logic [DATA_W-1:0] add_b;
  logic              carry_in;
  logic [DATA_W:0]   sum;
  logic [DATA_W-1:0] result;
  logic [3:0]        target;
  logic              arith;

  always_comb begin
    base = first_operand_val;
    if (first_operand_reg == `ALU_REG_PC) begin
      base = first_operand_val & DATA_W'(`ALU_PC_ALIGN);
    end
    opnd_b = flexible_operand;
    if (use_immediate || op == add_wide_immediate ||
        op == subtract_wide_immediate) begin
      opnd_b = DATA_W'(twelve_bit_immediate);
    end
    arith    = is_arith(op);
    add_a    = base;
    add_b    = opnd_b;
    carry_in = 1'b0;
    case (op)
      op_add, add_wide_immediate: begin
        carry_in = 1'b0;
      end
      op_add_with_carry: begin
        carry_in = flag_c_ff;
      end
      op_subtract, subtract_wide_immediate: begin
        add_b    = ~opnd_b;
        carry_in = 1'b1;
      end
      subtract_with_borrow: begin
        add_b    = ~opnd_b;
        carry_in = flag_c_ff;
      end
      reverse_subtract: begin
        add_a    = ~base;
        add_b    = opnd_b;
        carry_in = 1'b1;
      end
      default: begin
        carry_in = 1'b0;
      end
    endcase
    sum = {1'b0, add_a} + {1'b0, add_b} + {{DATA_W{1'b0}}, carry_in};
    case (op)
      op_and:       result = base & opnd_b;
      bitwise_or:   result = base | opnd_b;
      bitwise_xor:  result = base ^ opnd_b;
      bit_clear_op: result = base & ~opnd_b;
      or_not_op:    result = base | ~opnd_b;
      default:      result = sum[DATA_W-1:0];
    endcase
    // Logic ops always name a destination; omission only for arithmetic
    target = (dest_present || !arith) ? dest_reg : first_operand_reg;
    nxt_wr_en         = 1'b0;
    nxt_wr_reg        = wr_reg_ff;
    nxt_wr_data       = wr_data_ff;
    nxt_branch        = 1'b0;
    nxt_branch_target = branch_target_ff;
    nxt_n             = flag_n_ff;
    nxt_z             = flag_z_ff;
    nxt_c             = flag_c_ff;
    nxt_v             = flag_v_ff;
    if (issue_valid && cond_pass) begin
      if (target == `ALU_REG_PC && (op == op_add)) begin
        nxt_branch        = 1'b1;
        nxt_branch_target = result & DATA_W'(`ALU_BRANCH_MASK);
      end else begin
        nxt_wr_en   = 1'b1;
        nxt_wr_reg  = target;
        nxt_wr_data = result;
      end
      if (set_flags) begin
        nxt_n = result[DATA_W-1];
        nxt_z = (result == '0);
        if (arith) begin
          nxt_c = sum[DATA_W];
          nxt_v = (add_a[DATA_W-1] == add_b[DATA_W-1]) &&
                  (result[DATA_W-1] != add_a[DATA_W-1]);
        end else begin
          nxt_c = shifter_carry;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_en_ff         <= 1'b0;
      wr_reg_ff        <= 4'h0;
      wr_data_ff       <= '0;
      branch_ff        <= 1'b0;
      branch_target_ff <= '0;
      {flag_n_ff, flag_z_ff, flag_c_ff, flag_v_ff} <= `ALU_FLAGS_RST;
    end else begin
      wr_en_ff         <= nxt_wr_en;
      wr_reg_ff        <= nxt_wr_reg;
      wr_data_ff       <= nxt_wr_data;
      branch_ff        <= nxt_branch;
      branch_target_ff <= nxt_branch_target;
      flag_n_ff        <= nxt_n;
      flag_z_ff        <= nxt_z;
      flag_c_ff        <= nxt_c;
      flag_v_ff        <= nxt_v;
    end
  end

  sequence issue_false_s;
    issue_valid && !cond_pass;
  endsequence

  sequence issue_flags_s;
    issue_valid && cond_pass && set_flags;
  endsequence

  suppress_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    issue_false_s |=> !wr_en_ff && !branch_ff && $stable({flag_n_ff,
      flag_z_ff, flag_c_ff, flag_v_ff}))
    else $error("false condition changed state");

  flags_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    issue_valid && !set_flags |=> $stable({flag_n_ff, flag_z_ff,
      flag_c_ff, flag_v_ff}))
    else $error("flags changed without suffix");

  logic_v_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    issue_flags_s ##0 !is_arith(op) |=> $stable(flag_v_ff))
    else $error("logic op touched overflow");

  zero_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    issue_flags_s ##1 wr_en_ff |-> flag_z_ff == (wr_data_ff == '0))
    else $error("zero flag mismatch");

  add_result_a: assert property (@(posedge clk) disable iff (!reset_n)
    issue_valid && cond_pass && op == op_add && use_immediate &&
    first_operand_reg != `ALU_REG_PC && dest_present && dest_reg !=
    `ALU_REG_PC |=> wr_data_ff == $past(first_operand_val) +
      DATA_W'($past(twelve_bit_immediate)))
    else $error("immediate add wrong");

  default_dest_a: assert property (@(posedge clk) disable iff (!reset_n)
    issue_valid && cond_pass && is_arith(op) && !dest_present &&
    first_operand_reg != `ALU_REG_PC |=> wr_en_ff &&
      wr_reg_ff == $past(first_operand_reg))
    else $error("omitted destination not first operand");

  branch_align_a: assert property (@(posedge clk) disable iff (!reset_n)
    branch_ff |-> !branch_target_ff[0] && !wr_en_ff)
    else $error("branch target odd or written");

  rsb_result_a: assert property (@(posedge clk) disable iff (!reset_n)
    issue_valid && cond_pass && op == reverse_subtract && !use_immediate &&
    first_operand_reg != `ALU_REG_PC |=> wr_data_ff ==
      $past(flexible_operand) - $past(first_operand_val))
    else $error("reverse subtract wrong");

endmodule : add_sub_logic_alu

// file: verif/reg_file_model.sv
// Register file model that feeds first operand values
module reg_file_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_reg,
  input  wire logic [31:0] wr_data,
  input  wire logic [3:0]  rd_reg,
  output logic      [31:0] rd_val
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs_ff [16];
  // Distinct reset contents so no register is all zero straight after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++)
        regs_ff[i] <= {8{i[3:0]}} ^ 32'h5a5a_a5a5;
    end else if (wr_en) begin
      regs_ff[wr_reg] <= wr_data;
    end
  end
  assign rd_val = regs_ff[rd_reg];
endmodule : reg_file_model

// file: verif/tb_top.sv
// Self-checking bench for the add, subtract and logic datapath
module tb_top
  import alu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset_n, iv, cp_i, sf_i, ui_i, sc_i, dp_i, we, br;
  logic        fn, fz, fc, fv, e_we, e_br;
  alu_op_t     op_i, k;
  logic [11:0] im_i;
  logic [3:0]  rn_i, d_i, wreg, e_reg, e_f;
  logic [31:0] aval, fx_i, wdata, tgt, r1, r2, e_data, e_tgt, got;
  logic [31:0] rf [16];
  int          seed = 32'hcc82_a766;
  int          failures = 0;
  int          checks = 0;

  add_sub_logic_alu DUT (.clk(clk), .reset_n(reset_n), .issue_valid(iv),
    .op(op_i), .cond_pass(cp_i), .set_flags(sf_i), .use_immediate(ui_i),
    .twelve_bit_immediate(im_i), .first_operand_reg(rn_i),
    .first_operand_val(aval), .flexible_operand(fx_i), .shifter_carry(sc_i),
    .dest_present(dp_i), .dest_reg(d_i), .wr_en_ff(we), .wr_reg_ff(wreg),
    .wr_data_ff(wdata), .branch_ff(br), .branch_target_ff(tgt),
    .flag_n_ff(fn), .flag_z_ff(fz), .flag_c_ff(fc), .flag_v_ff(fv));
  reg_file_model partner (.clk(clk), .reset_n(reset_n), .wr_en(we),
    .wr_reg(wreg), .wr_data(wdata), .rd_reg(rn_i), .rd_val(aval));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk

  task summarize;
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task go(input alu_op_t o, input logic [3:0] n, input logic [3:0] d,
          input logic [31:0] fx, input logic [11:0] im,
          input logic cp, input logic sf, input logic ui,
          input logic dp, input logic sc);
    logic [31:0] a, b, x, y, lg, r;
    logic [32:0] s;
    logic        ci, ar, v;
    logic [3:0]  d2;
    a = (n == 4'hf) ? rf[n] & 32'hffff_fffc : rf[n];
    b = (ui || o >= add_wide_immediate) ? {20'h0, im} : fx;
    ar = (o <= reverse_subtract) || (o >= add_wide_immediate);
    x = (o == reverse_subtract) ? ~a : a;
    y = (o inside {op_subtract, subtract_with_borrow,
                   subtract_wide_immediate}) ? ~b : b;
    ci = (o inside {op_add_with_carry, subtract_with_borrow}) ? e_f[1] :
         (o inside {op_subtract, reverse_subtract, subtract_wide_immediate});
    s = {1'b0, x} + {1'b0, y} + {32'h0, ci};
    v = (x[31] == y[31]) && (s[31] != x[31]);
    case (o)
      op_and:       lg = a & b;
      bitwise_or:   lg = a | b;
      bitwise_xor:  lg = a ^ b;
      bit_clear_op: lg = a & ~b;
      default:      lg = a | ~b;
    endcase
    r = ar ? s[31:0] : lg;
    d2 = (ar && !dp) ? n : d;
    @(posedge clk);
    iv <= 1'b1;
    op_i <= o;
    rn_i <= n;
    d_i <= d;
    fx_i <= fx;
    im_i <= im;
    cp_i <= cp;
    sf_i <= sf;
    ui_i <= ui;
    dp_i <= dp;
    sc_i <= sc;
    @(posedge clk);
    iv <= 1'b0;
    #1;
    e_we = 1'b0;
    e_br = 1'b0;
    if (cp) begin
      if (sf) e_f = {r[31], r == 32'h0, ar ? s[32] : sc, ar ? v : e_f[0]};
      if (o == op_add && d2 == 4'hf) begin
        e_br = 1'b1;
        e_tgt = r & 32'hffff_fffe;
      end else begin
        e_we = 1'b1;
        e_reg = d2;
        e_data = r;
        rf[d2] = r;
      end
    end
    got = {22'h0, we, br, fn, fz, fc, fv, wreg};
    chk({22'h0, e_we, e_br, e_f, e_reg}, got);
    chk(e_data, wdata);
    chk(e_tgt, tgt);
  endtask : go

  initial begin
    {iv, cp_i, sf_i, ui_i, sc_i, dp_i, im_i, rn_i, d_i, fx_i} = '0;
    op_i = op_add;
    reset_n = 1'b0;
    {e_we, e_br, e_f, e_reg, e_data, e_tgt} = '0;
    for (int i = 0; i < 16; i++)
      rf[i] = {8{i[3:0]}} ^ 32'h5a5a_a5a5;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    r2 = $random(seed);
    go(op_add, 4'h3, 4'h4, r2, 12'hfff, 1, 1, 1, 1, 0);
    go(op_subtract, 4'hf, 4'h5, r2, 12'h7ff, 1, 0, 1, 1, 0);
    go(op_add, 4'hd, 4'hd, 32'h0000_0018, 12'h0, 1, 1, 0, 1, 0);
    go(op_add, 4'hf, 4'hf, 32'h0000_0103, 12'h0, 1, 0, 0, 1, 0);
    go(op_add, 4'h2, 4'h7, r2, 12'h0, 0, 1, 0, 1, 1);
    go(op_subtract, 4'h1, 4'h8, 32'hffff_ffff, 12'h0, 1, 1, 0, 1, 0);
    go(subtract_with_borrow, 4'h2, 4'h9, r2, 12'h0, 1, 1, 0, 0, 0);
    go(op_add_with_carry, 4'h6, 4'h1, r2, 12'h0, 1, 1, 0, 1, 1);
    for (int j = 0; j < 12; j++)
      go(alu_op_t'(j), 4'h4, 4'ha, r2, 12'h9c3, 1, 1, 0, 1, 1);
    repeat (300) begin
      r1 = $random(seed);
      r2 = $random(seed);
      k = alu_op_t'(r1[3:0] % 4'hc);
      go(k, r1[7:4] % 4'hd, r1[11:8] % 4'hd, r2, r1[23:12],
         r1[26:24] != 3'h0, r1[27], r1[28] && k inside {op_add, op_subtract},
         r1[29], r1[30]);
    end
    summarize();
  end

  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule : tb_top
